// >>> hdl/flash_cmd_defs.vh
// command codes, status bits, stream kinds and reset values of the command interface
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH

// command codes, compared against the low byte of a command write
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_READ_IDENT 8'h90
`define CMD_READ_QUERY 8'h98
`define CMD_CLEAR_STATUS 8'h50
`define CMD_WORD_PROGRAM 8'h40
`define CMD_BUFFER_PROGRAM 8'he8
`define CMD_CONFIRM 8'hd0
`define CMD_FACTORY_SETUP 8'h80
`define CMD_SUSPEND 8'hb0

// read modes
`define MODE_ARRAY 2'h0
`define MODE_STATUS 2'h1
`define MODE_IDENT 2'h2
`define MODE_QUERY 2'h3

// status register bit positions and reset value
`define SR_READY 7
`define SR_ERASE_ERR 5
`define SR_PROG_ERR 4
`define SR_VOLT_ERR 3
`define SR_LOCK_ERR 1
`define SR_RESET 8'h80

// kinds of entries on the program stream
`define KIND_WORD 3'h0
`define KIND_BUF_WORD 3'h1
`define KIND_BUF_GO 3'h2
`define KIND_FACT_GO 3'h3
`define KIND_FACT_WORD 3'h4

// program buffer capacity in words
`define BUF_CAPACITY 512

`endif

// >>> hdl/two_entry_buffer.v
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // filling side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] spare_q;
  reg full_q;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // slot zero drives the outputs directly; the spare slot absorbs one stalled word
  always @(posedge clock) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      spare_q <= {WIDTH{1'b0}};
      full_q <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      if (pop) begin
        if (full_q) begin
          out_data <= spare_q;
          full_q <= 1'b0;
          in_ready <= 1'b1;
        end else if (push) begin
          out_data <= in_data;
        end else begin
          out_valid <= 1'b0;
        end
      end else if (push) begin
        if (!out_valid) begin
          out_data <= in_data;
          out_valid <= 1'b1;
        end else begin
          spare_q <= in_data; // ready drops so the source stalls
          full_q <= 1'b1;
          in_ready <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> hdl/flash_command_interpreter.v
// command interface of a parallel flash: decodes host writes into read modes and program requests
//
// Functional notes
// R1 - code ff selects array reads
// R2 - code 70 selects status reads
// R3 - accepted program command switches to status reads
// R4 - code 90 selects identifier reads
// R5 - code 98 selects query reads
// R6 - code 50 clears error flags only
// R7 - after 40 next write programs one word
// R8 - while programming only status and suspend accepted (code acts on status only; suspend b0 is ignored)
// R9 - host toggles select or enable for status
// R10 - host toggles select or address valid
// R11 - host rewrites array read after programming
// R12 - code e8 loads up to 512 words
// R13 - confirm d0 starts buffered program
// R14 - code 80 arms factory mode, awaits d0
// R15 - factory mode ignores all other commands
// R16 - d0 after 80 captures address and data
// R17 - commands at any address, never stored
// R18 - host reissues setup after die switch
// R19 - capture on first rising write strobe
// R20 - reset gives array reads, status 80
// R21 - missing second code sets both error flags
// R22 - unknown code changes nothing
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"

module flash_command_interpreter #(
  parameter ADDR_W = 24,
  parameter BUF_WORDS = `BUF_CAPACITY
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // host bus pins, asynchronous to clock
  input wire we_n,
  input wire ce_n,
  input wire oe_n,
  input wire address_valid_n,
  input wire [ADDR_W-1:0] addr,
  input wire [15:0] dq_in,
  // program engine feedback, same clock
  input wire op_done,
  input wire op_error,
  // program request stream towards the engine
  output wire prog_valid,
  input wire prog_ready,
  output wire [2:0] prog_kind,
  output wire [ADDR_W-1:0] prog_addr,
  output wire [15:0] prog_data,
  // read path selection and status
  output reg [1:0] read_mode,
  output reg [7:0] status,
  output reg [7:0] status_view,
  output reg busy,
  output reg factory_program_mode,
  output reg write_lost
);

  // interpreter states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WP_SETUP = 3'h1;
  localparam [2:0] ST_BUF_COUNT = 3'h2;
  localparam [2:0] ST_BUF_LOAD = 3'h3;
  localparam [2:0] ST_BUF_CONFIRM = 3'h4;
  localparam [2:0] ST_FACT_SETUP = 3'h5;
  localparam [2:0] ST_FACT_MODE = 3'h6;
  localparam [2:0] ST_BUSY = 3'h7;

  localparam CNT_W = $clog2(BUF_WORDS);
  localparam [15:0] MAX_COUNT = BUF_WORDS - 1;
  localparam SW = 3 + ADDR_W + 16;

  // true while an operation owns the array
  function is_busy;
    input [2:0] st;
    begin
      is_busy = (st == ST_BUSY) || (st == ST_FACT_MODE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg we_m, we_s, ce_m, ce_s, oe_m, oe_s, adv_m, adv_s;
  reg [ADDR_W-1:0] addr_m, addr_s;
  reg [15:0] dq_m, dq_s;

  // two flops on every pin; strobes idle high so reset to one
  always @(posedge clock) begin
    if (!rst_n) begin
      {we_m, ce_m, oe_m, adv_m} <= 4'hf;
      {we_s, ce_s, oe_s, adv_s} <= 4'hf;
      addr_m <= {ADDR_W{1'b0}};
      addr_s <= {ADDR_W{1'b0}};
      dq_m <= 16'h0000;
      dq_s <= 16'h0000;
    end else begin
      {we_m, ce_m, oe_m, adv_m} <= {we_n, ce_n, oe_n, address_valid_n};
      {we_s, ce_s, oe_s, adv_s} <= {we_m, ce_m, oe_m, adv_m};
      addr_m <= addr;
      addr_s <= addr_m;
      dq_m <= dq_in;
      dq_s <= dq_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write cycle capture
  wire wr_active;
  wire wr_end;
  wire rd_active;
  reg wr_prev_q, rd_prev_q, adv_prev_q;
  reg [ADDR_W-1:0] wr_addr_q;
  reg [15:0] wr_data_q;
  reg pend_q;
  reg [ADDR_W-1:0] pend_addr_q;
  reg [15:0] pend_data_q;
  wire take;
  wire buf_ready;

  // a write needs both strobes low with outputs disabled
  assign wr_active = ~we_s & ~ce_s & oe_s;
  // the first of the two strobes to rise ends the active window
  assign wr_end = wr_prev_q & ~wr_active;
  assign rd_active = ~ce_s & ~oe_s;
  // a captured write is decoded only when the stream can accept an entry
  assign take = pend_q & buf_ready;

  // bus values are held while the window is open, so the rising edge itself is never sampled
  always @(posedge clock) begin
    if (!rst_n) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      adv_prev_q <= 1'b1;
      wr_addr_q <= {ADDR_W{1'b0}};
      wr_data_q <= 16'h0000;
      pend_q <= 1'b0;
      pend_addr_q <= {ADDR_W{1'b0}};
      pend_data_q <= 16'h0000;
      write_lost <= 1'b0;
    end else begin
      wr_prev_q <= wr_active;
      rd_prev_q <= rd_active;
      adv_prev_q <= adv_s;
      if (wr_active) begin
        wr_addr_q <= addr_s;
        wr_data_q <= dq_s;
      end
      write_lost <= 1'b0;
      // R19 first rising strobe
      if (wr_end) begin
        if (pend_q && !take) begin
          write_lost <= 1'b1; // host outran a stalled engine
        end else begin
          pend_q <= 1'b1;
          pend_addr_q <= wr_addr_q;
          pend_data_q <= wr_data_q;
        end
      end else if (take) begin
        pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  reg [2:0] state_q, state_d;
  reg [1:0] mode_d;
  reg [CNT_W-1:0] cnt_q, cnt_d;
  reg push;
  reg [2:0] push_kind;
  reg seq_err;
  reg clr_err;
  wire [7:0] cmd;
  // R17 address never decoded
  assign cmd = pend_data_q[7:0];
  // next state, read mode and stream push for one taken write
  always @* begin
    state_d = state_q;
    mode_d = read_mode;
    cnt_d = cnt_q;
    push = 1'b0;
    push_kind = `KIND_WORD;
    seq_err = 1'b0;
    clr_err = 1'b0;
    if (take) begin
      case (state_q)
        ST_IDLE: begin
          // R22 unknown code ignored
          case (cmd)
            // R1 array reads
            `CMD_READ_ARRAY: mode_d = `MODE_ARRAY;
            // R2 status reads
            `CMD_READ_STATUS: mode_d = `MODE_STATUS;
            // R4 identifier reads
            `CMD_READ_IDENT: mode_d = `MODE_IDENT;
            // R5 query reads
            `CMD_READ_QUERY: mode_d = `MODE_QUERY;
            // R6 clear error flags
            `CMD_CLEAR_STATUS: clr_err = 1'b1;
            // R3 auto status mode
            `CMD_WORD_PROGRAM: begin
              state_d = ST_WP_SETUP;
              mode_d = `MODE_STATUS;
            end
            // R12 buffered load start
            `CMD_BUFFER_PROGRAM: begin
              state_d = ST_BUF_COUNT;
              mode_d = `MODE_STATUS;
            end
            // R14 factory setup armed
            `CMD_FACTORY_SETUP: begin
              state_d = ST_FACT_SETUP;
              mode_d = `MODE_STATUS;
            end
            default: state_d = ST_IDLE;
          endcase
        end
        ST_WP_SETUP: begin
          // R7 next write programs
          push = 1'b1;
          push_kind = `KIND_WORD;
          state_d = ST_BUSY;
        end
        ST_BUF_COUNT: begin
          // R12 capacity check
          if (pend_data_q > MAX_COUNT) begin
            seq_err = 1'b1;
            state_d = ST_IDLE;
          end else begin
            cnt_d = pend_data_q[CNT_W-1:0];
            state_d = ST_BUF_LOAD;
          end
        end
        ST_BUF_LOAD: begin
          // R12 collect buffer words
          push = 1'b1;
          push_kind = `KIND_BUF_WORD;
          if (cnt_q == {CNT_W{1'b0}}) begin
            state_d = ST_BUF_CONFIRM;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        ST_BUF_CONFIRM: begin
          // R13 confirm starts program
          if (cmd == `CMD_CONFIRM) begin
            push = 1'b1;
            push_kind = `KIND_BUF_GO;
            state_d = ST_BUSY;
          end else begin
            // R21 sequence error
            seq_err = 1'b1;
            state_d = ST_IDLE;
          end
        end
        ST_FACT_SETUP: begin
          // R16 capture confirm cycle
          if (cmd == `CMD_CONFIRM) begin
            push = 1'b1;
            push_kind = `KIND_FACT_GO;
            state_d = ST_FACT_MODE;
          end else begin
            // R21 sequence error
            seq_err = 1'b1;
            state_d = ST_IDLE;
          end
        end
        ST_FACT_MODE: begin
          // R15 every write is data
          push = 1'b1;
          push_kind = `KIND_FACT_WORD;
        end
        ST_BUSY: begin
          // R8 status only; suspend ignored
          if (cmd == `CMD_READ_STATUS) begin
            mode_d = `MODE_STATUS;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    // the engine ends the operation; read mode stays status until the host asks
    if (op_done && is_busy(state_q)) begin
      state_d = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, status register and read path
  reg [7:0] sr_d;
  // error flags: hardware sets, only the clear command clears; a set in the clear cycle wins
  always @* begin
    sr_d = status;
    if (clr_err) begin
      sr_d[`SR_ERASE_ERR] = 1'b0;
      sr_d[`SR_PROG_ERR] = 1'b0;
      sr_d[`SR_VOLT_ERR] = 1'b0;
      sr_d[`SR_LOCK_ERR] = 1'b0;
    end
    // R21 both error flags
    if (seq_err) begin
      sr_d[`SR_ERASE_ERR] = 1'b1;
      sr_d[`SR_PROG_ERR] = 1'b1;
    end
    if (op_done && op_error && is_busy(state_q)) begin
      sr_d[`SR_PROG_ERR] = 1'b1;
    end
    sr_d[`SR_READY] = ~is_busy(state_d);
  end

  // R20 reset defaults
  always @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      read_mode <= `MODE_ARRAY;
      status <= `SR_RESET;
      busy <= 1'b0;
      factory_program_mode <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      read_mode <= mode_d;
      status <= sr_d;
      busy <= is_busy(state_d);
      factory_program_mode <= (state_d == ST_FACT_MODE);
    end
  end

  // R10 refresh on address valid
  // the snapshot only moves when a new read starts or address valid falls, so a held read sees stable bits
  always @(posedge clock) begin
    if (!rst_n) begin
      status_view <= `SR_RESET;
    end else if ((rd_active && !rd_prev_q) || (!adv_s && adv_prev_q)) begin
      status_view <= status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program request stream
  wire [SW-1:0] out_word;
  // stalling the engine holds the buffer full, which in turn holds decoding
  two_entry_buffer #(
    .WIDTH(SW)
  ) u_stream (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data({push_kind, pend_addr_q, pend_data_q}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(out_word)
  );
  assign prog_kind = out_word[SW-1:SW-3];
  assign prog_addr = out_word[SW-4:16];
  assign prog_data = out_word[15:0];

endmodule

`default_nettype wire

// >>> verif/flash_cmd_monitor.sv
// concurrent checks on the command interpreter ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"

module flash_cmd_monitor #(
  parameter ADDR_W = 24
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host strobe and engine feedback
  input wire logic we_n,
  input wire logic op_done,
  input wire logic op_error,
  // program stream
  input wire logic prog_valid,
  input wire logic prog_ready,
  input wire logic [2:0] prog_kind,
  input wire logic [15:0] prog_data,
  // mode and status
  input wire logic [1:0] read_mode,
  input wire logic [7:0] status,
  input wire logic busy,
  input wire logic factory_program_mode
);
  logic [7:0] quiet_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // cycles since the strobe was low; a stalled decode can lag, hence slack
  always @(posedge clock) begin
    if (!rst_n || !we_n)
      quiet_q <= 8'h00;
    else if (quiet_q != 8'hff)
      quiet_q <= quiet_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property (
    $rose(rst_n) |-> read_mode == `MODE_ARRAY && status == `SR_RESET && !busy)
    else $error("reset state wrong");
  a_ready_flag: assert property (
    status[`SR_READY] != busy)
    else $error("ready bit not inverse of busy");
  a_word_status: assert property (
    prog_valid && prog_kind == `KIND_WORD |-> busy && read_mode == `MODE_STATUS)
    else $error("word program without status mode");
  a_stream_hold: assert property (
    prog_valid && !prog_ready |=> prog_valid && $stable(prog_kind) && $stable(prog_data))
    else $error("stream entry changed before taken");
  a_done_release: assert property (
    busy && !factory_program_mode && op_done |=> !busy &&
      status[`SR_PROG_ERR] == ($past(op_error) || $past(status[`SR_PROG_ERR])))
    else $error("completion handled wrong");
  a_mode_cause: assert property (
    $changed(read_mode) |-> quiet_q < 8'd12)
    else $error("read mode changed without a write");
  a_factory_hold: assert property (
    factory_program_mode |=> factory_program_mode && busy && $stable(read_mode))
    else $error("factory mode left or mode changed");
  a_busy_mode: assert property (
    busy && $changed(read_mode) |-> read_mode == `MODE_STATUS)
    else $error("mode command taken while busy");
  // main scenarios reached
  c_word: cover property (prog_valid && prog_ready && prog_kind == `KIND_WORD);
  c_go: cover property (prog_valid && prog_ready && prog_kind == `KIND_BUF_GO);
  c_fact: cover property ($rose(factory_program_mode));
  c_err: cover property ($fell(status[`SR_PROG_ERR]));
endmodule
`default_nettype wire

// >>> verif/prog_engine_model.sv
// program engine model: takes stream entries and reports finished programs
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"

module prog_engine_model #(
  parameter ADDR_W = 24,
  parameter DELAY = 30
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // stream from the interpreter
  input wire logic prog_valid,
  output logic prog_ready,
  input wire logic [2:0] prog_kind,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  // test controls
  input wire logic stall,
  input wire logic fail,
  // completion
  output logic op_done,
  output logic op_error
);
  logic [2:0] k_log [0:15];
  logic [ADDR_W-1:0] a_log [0:15];
  logic [15:0] d_log [0:15];
  int taken;
  int timer;
  // stalling is a test control so the two-entry buffer gets filled
  assign prog_ready = !stall;
  ////////////////////////////////////////////////////////////////////////
  // a word or buffer go runs, then reports once
  always @(posedge clock) begin
    op_done <= 1'b0;
    op_error <= 1'b0;
    if (!rst_n) begin
      taken <= 0;
      timer <= 0;
    end else begin
      if (timer == 1) begin
        op_done <= 1'b1;
        op_error <= fail;
      end
      if (timer > 0)
        timer <= timer - 1;
      if (prog_valid && prog_ready) begin
        k_log[taken[3:0]] <= prog_kind;
        a_log[taken[3:0]] <= prog_addr;
        d_log[taken[3:0]] <= prog_data;
        taken <= taken + 1;
        if (prog_kind == `KIND_WORD || prog_kind == `KIND_BUF_GO)
          timer <= DELAY;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/flash_command_interpreter_tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"

module flash_command_interpreter_tb;
  logic clock, rst_n, we_n, ce_n, oe_n, address_valid_n, stall, fail;
  logic lost_seen = 1'b0;
  logic [23:0] addr;
  logic [15:0] dq_in;
  wire logic prog_valid, prog_ready, op_done, op_error, busy, factory_program_mode, write_lost;
  wire logic [2:0] prog_kind;
  wire logic [23:0] prog_addr;
  wire logic [15:0] prog_data;
  wire logic [1:0] read_mode;
  wire logic [7:0] status, status_view;
  int fails = 0;
  int samples_checked = 0;
  int base;
  flash_command_interpreter u_dut (.clock(clock), .rst_n(rst_n), .we_n(we_n), .ce_n(ce_n),
    .oe_n(oe_n), .address_valid_n(address_valid_n), .addr(addr), .dq_in(dq_in),
    .op_done(op_done), .op_error(op_error), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_kind(prog_kind), .prog_addr(prog_addr), .prog_data(prog_data),
    .read_mode(read_mode), .status(status), .status_view(status_view), .busy(busy),
    .factory_program_mode(factory_program_mode), .write_lost(write_lost));
  prog_engine_model u_eng (.clock(clock), .rst_n(rst_n), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_kind(prog_kind), .prog_addr(prog_addr),
    .prog_data(prog_data), .stall(stall), .fail(fail), .op_done(op_done), .op_error(op_error));
  ////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // a dropped write is a pulse, so keep it
  always @(posedge clock)
    if (write_lost === 1'b1)
      lost_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobes held low four cycles so the synchroniser sees them
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clock);
    #2;
    addr = a;
    dq_in = d;
    we_n = 1'b0;
    ce_n = 1'b0;
    repeat (4) @(posedge clock);
    #2;
    we_n = 1'b1;
    ce_n = 1'b1;
    repeat (7) @(posedge clock);
    #2;
  endtask
  task automatic ent(input int i, input logic [2:0] k, input logic [23:0] a,
                     input logic [15:0] d);
    chk(u_eng.k_log[i], k);
    chk(u_eng.a_log[i], a);
    chk(u_eng.d_log[i], d);
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 300) begin
      @(posedge clock);
      #2;
      i++;
    end
    chk(busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(read_mode, `MODE_ARRAY);
    chk(status, `SR_RESET);
    chk(prog_valid, 1'b0);
    $display("test reset finished");
  endtask
  // every read mode code, each at another address, then an unknown code
  task automatic t_modes;
    logic [7:0] codes [4] = '{`CMD_READ_STATUS, `CMD_READ_IDENT, `CMD_READ_ARRAY,
                              `CMD_READ_QUERY};
    logic [1:0] modes [4] = '{`MODE_STATUS, `MODE_IDENT, `MODE_ARRAY, `MODE_QUERY};
    for (int i = 0; i < 4; i++) begin
      wr(24'h123457 * i, {8'h00, codes[i]});
      chk(read_mode, modes[i]);
    end
    wr(24'h000000, 16'h0012);
    chk(read_mode, `MODE_QUERY);
    chk(status, `SR_RESET);
    $display("test modes finished");
  endtask
  task automatic t_word;
    base = u_eng.taken;
    fail = 1'b1;
    wr(24'h000000, 16'h0040);
    chk(read_mode, `MODE_STATUS);
    wr(24'h00abcd, 16'h5a5a);
    chk(busy, 1'b1);
    wr(24'h000000, 16'h00ff);
    chk(read_mode, `MODE_STATUS);
    wait_idle;
    ent(base, `KIND_WORD, 24'h00abcd, 16'h5a5a);
    chk(status, 8'h90);
    chk(read_mode, `MODE_STATUS);
    oe_n = 1'b0;
    ce_n = 1'b0;
    repeat (4) @(posedge clock);
    #2;
    oe_n = 1'b1;
    ce_n = 1'b1;
    chk(status_view, 8'h90);
    fail = 1'b0;
    wr(24'h000000, 16'h0050);
    chk(status, `SR_RESET);
    chk(status_view, 8'h90);
    address_valid_n = 1'b0;
    repeat (4) @(posedge clock);
    #2;
    address_valid_n = 1'b1;
    chk(status_view, `SR_RESET);
    $display("test word finished");
  endtask
  task automatic t_seq_err;
    wr(24'h000000, 16'h0080);
    wr(24'h000000, 16'h00ff);
    chk(status, 8'hb0);
    wr(24'h000000, 16'h0050);
    wr(24'h000000, 16'h00e8);
    wr(24'h000000, 16'h0200);
    chk(status, 8'hb0);
    wr(24'h000000, 16'h0050);
    chk(status, `SR_RESET);
    $display("test sequence error finished");
  endtask
  // engine stalls so the buffer fills and one write is refused
  task automatic t_buffer;
    base = u_eng.taken;
    stall = 1'b1;
    wr(24'h000010, 16'h00e8);
    wr(24'h000010, 16'h0001);
    wr(24'h000010, 16'h1111);
    wr(24'h000011, 16'h2222);
    wr(24'h000010, 16'h00d0);
    wr(24'h000010, 16'h0070);
    chk(lost_seen, 1'b1);
    chk(u_eng.taken - base, 0);
    stall = 1'b0;
    repeat (8) @(posedge clock);
    #2;
    wait_idle;
    chk(u_eng.taken - base, 3);
    ent(base, `KIND_BUF_WORD, 24'h000010, 16'h1111);
    ent(base + 1, `KIND_BUF_WORD, 24'h000011, 16'h2222);
    chk(u_eng.k_log[base + 2], `KIND_BUF_GO);
    chk(read_mode, `MODE_STATUS);
    $display("test buffer finished");
  endtask
  task automatic t_factory;
    base = u_eng.taken;
    wr(24'h000000, 16'h0080);
    wr(24'h000100, 16'h00d0);
    ent(base, `KIND_FACT_GO, 24'h000100, 16'h00d0);
    chk(factory_program_mode, 1'b1);
    wr(24'h000102, 16'h00ff);
    ent(base + 1, `KIND_FACT_WORD, 24'h000102, 16'h00ff);
    chk(read_mode, `MODE_STATUS);
    $display("test factory finished");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {we_n, ce_n, oe_n, address_valid_n} = 4'hf;
    addr = 24'h000000;
    dq_in = 16'h0000;
    stall = 1'b0;
    fail = 1'b0;
    repeat (20) @(posedge clock);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    #2;
    t_reset;
    t_modes;
    t_word;
    t_seq_err;
    t_buffer;
    t_factory;
    test_done;
  end
  // about 360 cycles expected
  initial begin
    repeat (6000) @(posedge clock);
    fails++;
    test_done;
  end
endmodule

bind flash_command_interpreter flash_cmd_monitor #(.ADDR_W(ADDR_W)) u_mon (.clock(clock),
  .rst_n(rst_n), .we_n(we_n), .op_done(op_done), .op_error(op_error),
  .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_kind(prog_kind),
  .prog_data(prog_data), .read_mode(read_mode), .status(status), .busy(busy),
  .factory_program_mode(factory_program_mode));
`default_nettype wire
